/* File: rcs_pkg.sv */
// package with register map, field layout and types of the reference clock select block
package rcs_pkg;

   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned NUM_RX_CLOCKS = 22;
   localparam int unsigned NUM_SUM_CH = 16;

   // byte addresses on the apb bus
   localparam logic [11:0] ADDR_REF_CFG = 12'h280;
   localparam logic [11:0] ADDR_SUM_CH1_8 = 12'h2c0;
   localparam logic [11:0] ADDR_SUM_CH9_16 = 12'h300;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h400;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h404;

   // secondary reference configuration field positions
   localparam int unsigned REF_OE_BIT = 6;
   localparam int unsigned REF_E1_BIT = 5;
   localparam int unsigned REF_SEL_LSB = 0;
   localparam int unsigned REF_SEL_W = 5;
   localparam logic [7:0] REF_CFG_RESET = 8'h41;
   localparam logic [7:0] REF_CFG_WMASK = 8'h7f;

   // highest code that still names a recovered channel clock
   localparam logic [4:0] SEL_LAST_CHANNEL = 5'h15;

   localparam logic [7:0] SUM_RESET = 8'h00;
   localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;
   localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;

   typedef struct packed {
      logic reserved;
      logic output_enable;
      logic ext_clock_is_e1;
      logic [4:0] source_select;
   } rcs_ref_cfg_t;

   typedef struct packed {
      logic [7:0] channels_9_to_16;
      logic [7:0] channels_1_to_8;
   } rcs_summary_t;

   function automatic logic sel_is_external(input logic [4:0] sel);
      sel_is_external = (sel > SEL_LAST_CHANNEL);
   endfunction

endpackage

/* File: rcs_ref_select.sv */
// secondary reference clock source selector with output enable
module rcs_ref_select #(
   parameter int unsigned NUM_CLOCKS = rcs_pkg::NUM_RX_CLOCKS
) (
   input wire logic clk,
   input wire logic reset,
   input wire rcs_pkg::rcs_ref_cfg_t cfg,
   input wire logic [NUM_CLOCKS-1:0] rx_clocks,
   input wire logic ext_clock,
   output logic ref_out,
   output logic ref_oe
);

   logic ref_out_reg;
   logic ref_oe_reg;
   wire logic use_ext;
   wire logic chan_clock;
   wire logic picked;

   assign use_ext = rcs_pkg::sel_is_external(cfg.source_select); // see [RULE4]
   assign chan_clock = use_ext ? 1'b0 : rx_clocks[cfg.source_select]; // see [RULE3]
   assign picked = use_ext ? ext_clock : chan_clock; // see [RULE4]

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ref_out_reg <= 1'b0;
         ref_oe_reg <= 1'b0;
      end else begin
         ref_out_reg <= picked;
         ref_oe_reg <= cfg.output_enable; // see [RULE1]
      end
   end

   assign ref_out = ref_out_reg;
   assign ref_oe = ref_oe_reg;

endmodule

/* File: rcs_irq_summary.sv */
// per-channel pending summary with sticky event status, mask and interrupt line
module rcs_irq_summary #(
   parameter int unsigned NUM_CH = rcs_pkg::NUM_SUM_CH
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [NUM_CH-1:0] pending,
   input wire logic status_clear,
   input wire logic [NUM_CH-1:0] mask,
   output logic [NUM_CH-1:0] summary,
   output logic [NUM_CH-1:0] status,
   output logic irq
);

   logic [NUM_CH-1:0] summary_reg;
   logic [NUM_CH-1:0] status_reg;
   logic [NUM_CH-1:0] status_next;
   logic irq_reg;
   wire logic [NUM_CH-1:0] rising;

   assign rising = pending & ~summary_reg;
   // a new event in the clearing cycle survives the clear
   assign status_next = (status_clear ? '0 : status_reg) | rising;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         summary_reg <= '0;
         status_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         summary_reg <= pending; // see [RULE8]
         status_reg <= status_next;
         irq_reg <= |(status_next & ~mask);
      end
   end

   assign summary = summary_reg;
   assign status = status_reg;
   assign irq = irq_reg;

endmodule

/* File: rcs_ref_clock_regs.sv */
// apb register slice: secondary reference clock select and channel interrupt summaries
// Operation
// [RULE1] output enable 1 drives selected clock on reference pin, 0 releases it
// [RULE2] frequency bit 1 marks external clock as e1 rate; software sets it
// [RULE3] select codes 0 to 21 route that channel's recovered receive clock
// [RULE4] select codes 22 to 31 route the external clock input instead
// [RULE5] configuration register resets to 41h: enabled, bit clear, channel 1
// [RULE6] first summary register bits 7..0 show channels 8..1
// [RULE7] second summary register bits 7..0 show channels 16..9
// [RULE8] summary bit is 1 while its channel has a pending interrupt, else 0
// [RULE9] reserved bit 7 of configuration reads zero and ignores writes
//
// Implementation choice: the APB slave port.
module rcs_ref_clock_regs (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [rcs_pkg::NUM_RX_CLOCKS-1:0] rx_recovered_clocks,
   input wire logic secondary_external_clock_input,
   input wire logic [rcs_pkg::NUM_SUM_CH-1:0] channel_irq_pending,
   output logic secondary_reference_pin_o,
   output logic secondary_reference_pin_oe,
   output logic secondary_ext_clock_is_e1,
   output logic irq
);

   rcs_pkg::rcs_ref_cfg_t ref_cfg_reg;
   rcs_pkg::rcs_ref_cfg_t ref_cfg_next;
   logic [15:0] irq_mask_reg;
   logic [15:0] irq_mask_next;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic is_e1_reg;

   rcs_pkg::rcs_summary_t summary;
   logic [15:0] summary_bits;
   logic [15:0] irq_status;
   logic ref_pin;
   logic ref_pin_oe;
   logic irq_line;

   // address decode
   wire logic hit_cfg;
   wire logic hit_sum1;
   wire logic hit_sum2;
   wire logic hit_status;
   wire logic hit_mask;
   wire logic hit_any;
   wire logic setup_phase;
   wire logic access_done;
   wire logic wr_cfg;
   wire logic wr_mask;
   wire logic rd_status;
   wire logic [31:0] read_mux;

   assign hit_cfg = (paddr == rcs_pkg::ADDR_REF_CFG);
   assign hit_sum1 = (paddr == rcs_pkg::ADDR_SUM_CH1_8);
   assign hit_sum2 = (paddr == rcs_pkg::ADDR_SUM_CH9_16);
   assign hit_status = (paddr == rcs_pkg::ADDR_IRQ_STATUS);
   assign hit_mask = (paddr == rcs_pkg::ADDR_IRQ_MASK);
   assign hit_any = hit_cfg | hit_sum1 | hit_sum2 | hit_status | hit_mask;

   // one wait-free access: pready rises in the cycle after setup
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready_reg;
   assign wr_cfg = access_done & pwrite & hit_cfg & pstrb[0];
   assign wr_mask = access_done & pwrite & hit_mask;
   // clear at the edge that captures the read data, so no event falls between them
   assign rd_status = setup_phase & ~pwrite & hit_status;

   // summary registers are read-only views; writes to them are dropped
   assign summary = summary_bits;

   assign read_mux =
      hit_cfg ? {24'h000000, 1'b0, ref_cfg_reg[6:0]} : // see [RULE9]
      hit_sum1 ? {24'h000000, summary.channels_1_to_8} : // see [RULE6]
      hit_sum2 ? {24'h000000, summary.channels_9_to_16} : // see [RULE7]
      hit_status ? {16'h0000, irq_status} :
      hit_mask ? {16'h0000, irq_mask_reg} :
      32'h00000000;

   // reserved bit never stored, so it cannot be written
   assign ref_cfg_next = wr_cfg ?
      rcs_pkg::rcs_ref_cfg_t'(pwdata[7:0] & rcs_pkg::REF_CFG_WMASK) : ref_cfg_reg; // see [RULE9]

   assign irq_mask_next = {
      (wr_mask & pstrb[1]) ? pwdata[15:8] : irq_mask_reg[15:8],
      (wr_mask & pstrb[0]) ? pwdata[7:0] : irq_mask_reg[7:0]
   };

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ref_cfg_reg <= rcs_pkg::rcs_ref_cfg_t'(rcs_pkg::REF_CFG_RESET); // see [RULE5]
         irq_mask_reg <= rcs_pkg::IRQ_MASK_RESET;
         is_e1_reg <= 1'b0;
      end else begin
         ref_cfg_reg <= ref_cfg_next;
         irq_mask_reg <= irq_mask_next;
         is_e1_reg <= ref_cfg_next.ext_clock_is_e1; // see [RULE2]
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= setup_phase;
         pslverr_reg <= setup_phase & ~hit_any;
         prdata_reg <= (setup_phase & ~pwrite) ? read_mux : 32'h00000000;
      end
   end

   rcs_ref_select #(
      .NUM_CLOCKS(rcs_pkg::NUM_RX_CLOCKS)
   ) u_ref_select (
      .clk(clk),
      .reset(reset),
      .cfg(ref_cfg_reg),
      .rx_clocks(rx_recovered_clocks),
      .ext_clock(secondary_external_clock_input),
      .ref_out(ref_pin),
      .ref_oe(ref_pin_oe)
   );

   rcs_irq_summary #(
      .NUM_CH(rcs_pkg::NUM_SUM_CH)
   ) u_irq_summary (
      .clk(clk),
      .reset(reset),
      .pending(channel_irq_pending), // see [RULE8]
      .status_clear(rd_status),
      .mask(irq_mask_reg),
      .summary(summary_bits),
      .status(irq_status),
      .irq(irq_line)
   );

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign secondary_reference_pin_o = ref_pin; // see [RULE1]
   assign secondary_reference_pin_oe = ref_pin_oe; // see [RULE1]
   assign secondary_ext_clock_is_e1 = is_e1_reg;
   assign irq = irq_line;

endmodule

/* File: rcs_chk.sv */
// assertion checker for the reference clock select register slice
module rcs_chk (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [rcs_pkg::NUM_RX_CLOCKS-1:0] rx_recovered_clocks,
   input wire logic secondary_external_clock_input,
   input wire logic secondary_reference_pin_o,
   input wire logic secondary_reference_pin_oe,
   input wire logic secondary_ext_clock_is_e1
);
   logic [7:0] sh_reg;
   logic live_reg;
   wire logic acc = psel && penable && pready;
   wire logic hit = paddr == rcs_pkg::ADDR_REF_CFG;
   wire logic mapped = hit || paddr == rcs_pkg::ADDR_SUM_CH1_8 || paddr == rcs_pkg::ADDR_SUM_CH9_16
      || paddr == rcs_pkg::ADDR_IRQ_STATUS || paddr == rcs_pkg::ADDR_IRQ_MASK;
   wire logic [7:0] sh_next = (acc && pwrite && hit && pstrb[0]) ?
      (pwdata[7:0] & rcs_pkg::REF_CFG_WMASK) : sh_reg;
   wire logic [4:0] sel = sh_reg[4:0];
   wire logic oe_cfg = sh_reg[6];
   wire logic e1_cfg = sh_reg[5];
   // shadow of the selected source, external for codes above the last channel
   wire logic src = (sel > rcs_pkg::SEL_LAST_CHANNEL) ? secondary_external_clock_input
      : rx_recovered_clocks[sel];
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sh_reg <= rcs_pkg::REF_CFG_RESET;
         live_reg <= 1'h0;
      end else begin
         sh_reg <= sh_next;
         live_reg <= 1'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_ack;
      pready ##1 !pready;
   endsequence
   a_ready_pulse: assert property (s_setup |=> s_ack) else $error("pready not one cycle");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
   a_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("read data outside access");
   a_oe_follow: assert property (
      live_reg |-> secondary_reference_pin_oe == $past(oe_cfg))
      else $error("output enable wrong");
   // the frequency flag is loaded together with the configuration register
   a_e1_follow: assert property (live_reg |-> secondary_ext_clock_is_e1 == e1_cfg)
      else $error("frequency bit wrong");
   a_pin_source: assert property (
      live_reg |-> secondary_reference_pin_o == $past(src))
      else $error("reference pin source wrong");
   a_cfg_read: assert property (
      acc && !pwrite && hit |-> prdata == {24'h000000, sh_reg})
      else $error("configuration readback wrong");
endmodule

bind rcs_ref_clock_regs rcs_chk u_chk (.*);

/* File: tb_rcs_ref_clock_regs.sv */
// self-checking bench for the reference clock select register slice
module tb_rcs_ref_clock_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, irq, e;
   logic secondary_external_clock_input, secondary_reference_pin_o;
   logic secondary_reference_pin_oe, secondary_ext_clock_is_e1;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0] pstrb;
   logic [21:0] rx_recovered_clocks, oh;
   logic [15:0] channel_irq_pending;
   int err_count = 0;
   int n_checks = 0;
   rcs_ref_clock_regs dut (.*);
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'h1;
      // only the watchdog limits this wait
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0, 4'h0);
      chk(r, x);
   endtask
   initial begin
      {reset, psel, penable, pwrite, secondary_external_clock_input} = 5'h10;
      {paddr, pwdata, pstrb} = 48'h0;
      rx_recovered_clocks = 22'h0;
      channel_irq_pending = 16'h0;
      tick(8);
      reset <= 1'h0;
      tick(2);
      chk(32'(secondary_reference_pin_oe), 32'h1);
      chk(32'(secondary_ext_clock_is_e1), 32'h0);
      rd(12'h280, 32'h41);
      rd(12'h2c0, 32'h0);
      rd(12'h300, 32'h0);
      rd(12'h104, 32'h0);
      chk(32'(e), 32'h1);
      for (int c = 0; c < 32; c++) begin
         apb(1'h1, 12'h280, 32'h60 | c, 4'h1);
         oh = 22'h1 << c;
         rx_recovered_clocks <= oh;
         secondary_external_clock_input <= (c > 21);
         tick(2);
         chk(32'(secondary_reference_pin_o), 32'h1);
         chk(32'(secondary_ext_clock_is_e1), 32'h1);
         rx_recovered_clocks <= ~oh;
         secondary_external_clock_input <= (c < 22);
         tick(2);
         chk(32'(secondary_reference_pin_o), 32'h0);
      end
      apb(1'h1, 12'h280, 32'h1f, 4'h1);
      tick(2);
      chk(32'(secondary_reference_pin_oe), 32'h0);
      chk(32'(secondary_ext_clock_is_e1), 32'h0);
      apb(1'h1, 12'h280, 32'hff, 4'h1);
      apb(1'h1, 12'h280, 32'h0, 4'h0);
      rd(12'h280, 32'h7f);
      chk(32'(secondary_reference_pin_oe), 32'h1);
      channel_irq_pending <= 16'ha55a;
      tick(3);
      chk(32'(irq), 32'h1);
      rd(12'h2c0, 32'h5a);
      apb(1'h1, 12'h300, 32'h0, 4'hf);
      rd(12'h300, 32'ha5);
      apb(1'h1, 12'h404, 32'hffff, 4'h3);
      tick(2);
      chk(32'(irq), 32'h0);
      rd(12'h404, 32'hffff);
      apb(1'h1, 12'h404, 32'h0, 4'h3);
      channel_irq_pending <= 16'h0;
      tick(2);
      chk(32'(irq), 32'h1);
      rd(12'h400, 32'ha55a);
      tick(2);
      chk(32'(irq), 32'h0);
      rd(12'h400, 32'h0);
      rd(12'h2c0, 32'h0);
      summarize();
   end
   initial begin
      tick(3000);
      err_count++;
      summarize();
   end
endmodule
